// ==== trig_io_pkg.sv ====
// Constants, types and reset values for the camera trigger I/O block.
// Assumes a 50 MHz pclk and an APB master with 32-bit data.
package trig_io_pkg;
  // Clock period and derived cycle counts
  localparam int CLK_NS = 20;
  localparam int STRETCH_NS = 50;
  localparam int STRETCH_CYC = (STRETCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_NS = 500;
  localparam int PULSE_CYC = PULSE_NS / CLK_NS;
  localparam int US_NS = 1000;
  localparam int US_CYC = US_NS / CLK_NS;
  localparam logic [1:0] STRETCH_LOAD = 2'(STRETCH_CYC - 1);
  localparam logic [4:0] PULSE_LOAD = 5'(PULSE_CYC);
  localparam logic [5:0] US_LAST = 6'(US_CYC - 1);
  // Sensor readout time and largest offset, in microseconds
  localparam logic [20:0] READOUT_US = 21'h00E7E;
  localparam logic [10:0] OFFSET_MAX_US = 11'h739;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INT = 8'h04;
  localparam logic [7:0] ADDR_SCANS = 8'h08;
  localparam logic [7:0] ADDR_OFFSET = 8'h0C;
  localparam logic [7:0] ADDR_CMD = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // Status field positions
  localparam int STAT_OUT_EN = 3;
  localparam int STAT_ARMED = 4;
  localparam int STAT_ACQ = 5;
  localparam int STAT_PEND = 6;
  localparam int STAT_XFER = 7;
  // Reset values of the parameters
  localparam logic [20:0] RST_INT_US = 21'h003E8;
  localparam logic [15:0] RST_SCANS = 16'h0001;
  typedef enum logic [2:0] {
    MODE_SW_START = 3'b000, MODE_HW_START = 3'b001,
    MODE_HW_ENABLE = 3'b010, MODE_SINGLE = 3'b011,
    MODE_EXT_SYNC = 3'b100
  } mode_type;
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000, CMD_OUT_ON = 3'b001, CMD_OUT_OFF = 3'b010,
    CMD_START = 3'b011, CMD_STOP = 3'b100
  } cmd_type;
  typedef enum logic [2:0] {
    ST_CALC = 3'b000, ST_RUN = 3'b001, ST_READY = 3'b010,
    ST_INTEG = 3'b011, ST_READOUT = 3'b100, ST_XFER = 3'b101
  } state_type;
  // APB request and answer
  typedef struct packed {
    logic psel; logic penable; logic pwrite;
    logic [7:0] paddr; logic [31:0] pwdata;
  } apb_in_type;
  typedef struct packed {
    logic [31:0] prdata; logic pready; logic pslverr;
  } apb_out_type;
  // Whole state of the controller
  typedef struct packed {
    state_type state; mode_type mode; cmd_type pend_cmd;
    logic [20:0] int_us; logic [15:0] scans; logic [10:0] offset_us;
    logic out_en; logic pend; logic [1:0] str_cnt; logic str;
    logic sync1; logic sync2; logic sync_prev; logic [5:0] us_div;
    logic [20:0] frame_us; logic [20:0] frame_len; logic armed;
    logic acquiring; logic [15:0] frames; logic [4:0] pulse_cnt;
    logic trig_out; logic xfer_req; logic [31:0] prdata;
  } ctl_type;
  localparam ctl_type CTL_RESET = '{state: ST_CALC, mode: MODE_SW_START,
    pend_cmd: CMD_NONE, int_us: RST_INT_US, scans: RST_SCANS,
    default: '0};
endpackage

// ==== trig_io_ctrl.sv ====
// Trigger input conditioning, frame timing and trigger output pulse.
// Assumes an APB master on pclk and a host that fetches frame data.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module trig_io_ctrl (
  input logic pclk,
  input logic presetn,
  input trig_io_pkg::apb_in_type apb_in,
  output trig_io_pkg::apb_out_type apb_out,
  input logic trig_in,
  input logic data_fetched,
  output logic trig_out,
  output logic xfer_req
);
  trig_io_pkg::ctl_type st_reg; // Registered state
  trig_io_pkg::ctl_type st_next; // Next state
  logic acc; // APB access phase
  logic bad; // Refused access
  logic cfg_wr; // Accepted parameter write
  logic cmd_wr; // Command write, queued
  logic exec; // Queued command runs now
  logic edge_seen; // Synchronised rising edge
  logic tick; // One microsecond elapsed
  logic fire; // Output pulse event
  logic frame_end; // Frame closes this cycle
  logic [20:0] tpos; // Output position in frame

  // Mapped register addresses
  function automatic logic addr_ok(input logic [7:0] a);
    return a inside {trig_io_pkg::ADDR_CTRL, trig_io_pkg::ADDR_INT,
      trig_io_pkg::ADDR_SCANS, trig_io_pkg::ADDR_OFFSET,
      trig_io_pkg::ADDR_CMD, trig_io_pkg::ADDR_STATUS};
  endfunction

  // Parameter registers whose write reconfigures timing
  function automatic logic is_cfg(input logic [7:0] a);
    return a inside {trig_io_pkg::ADDR_CTRL, trig_io_pkg::ADDR_INT,
      trig_io_pkg::ADDR_SCANS, trig_io_pkg::ADDR_OFFSET};
  endfunction

  // Microsecond in the frame at which the output fires
  function automatic logic [20:0] trig_at(input logic [20:0] iu,
    input logic [20:0] fl, input logic [10:0] off);
    logic [20:0] pos;
    pos = fl - iu;
    if (iu >= trig_io_pkg::READOUT_US)
      trig_at = 21'h000000;
    else if ({10'h000, off} > pos)
      trig_at = 21'h000000;
    else
      trig_at = pos - {10'h000, off};
  endfunction

  // Bus decode; zero-wait access, data prepared in setup
  assign acc = apb_in.psel & apb_in.penable;
  assign bad = !addr_ok(apb_in.paddr) | (apb_in.pwrite
    & is_cfg(apb_in.paddr) & (st_reg.state == trig_io_pkg::ST_XFER));
  assign cfg_wr = acc & apb_in.pwrite & !bad & is_cfg(apb_in.paddr);
  assign cmd_wr = acc & apb_in.pwrite
    & (apb_in.paddr == trig_io_pkg::ADDR_CMD);
  assign apb_out.pready = acc;
  assign apb_out.pslverr = acc & bad;
  assign apb_out.prdata = st_reg.prdata;
  assign edge_seen = st_reg.sync2 & !st_reg.sync_prev;
  assign tick = st_reg.us_div == trig_io_pkg::US_LAST;
  // Commands are held back while data awaits the host
  assign exec = st_reg.pend & (st_reg.state != trig_io_pkg::ST_XFER)
    & (st_reg.state != trig_io_pkg::ST_CALC);
  assign tpos = trig_at(st_reg.int_us, st_reg.frame_len,
    st_reg.offset_us);
  assign trig_out = st_reg.trig_out;
  assign xfer_req = st_reg.xfer_req;

  // Next-state logic
  always_comb
  begin
    st_next = st_reg;
    fire = 1'b0;
    frame_end = 1'b0;
    // Read data captured in the setup cycle
    if (apb_in.psel & !apb_in.penable & !apb_in.pwrite)
    begin
      case (apb_in.paddr)
        trig_io_pkg::ADDR_CTRL: st_next.prdata = {29'h0, st_reg.mode};
        trig_io_pkg::ADDR_INT: st_next.prdata = {11'h0, st_reg.int_us};
        trig_io_pkg::ADDR_SCANS: st_next.prdata = {16'h0, st_reg.scans};
        trig_io_pkg::ADDR_OFFSET:
          st_next.prdata = {21'h0, st_reg.offset_us};
        trig_io_pkg::ADDR_STATUS:
        begin
          st_next.prdata = {st_reg.frames, 13'h0, st_reg.state};
          st_next.prdata[trig_io_pkg::STAT_OUT_EN] = st_reg.out_en;
          st_next.prdata[trig_io_pkg::STAT_ARMED] = st_reg.armed;
          st_next.prdata[trig_io_pkg::STAT_ACQ] = st_reg.acquiring;
          st_next.prdata[trig_io_pkg::STAT_PEND] = st_reg.pend;
          st_next.prdata[trig_io_pkg::STAT_XFER] = st_reg.xfer_req;
        end
        default: st_next.prdata = 32'h0; // Command and holes
      endcase
    end
    // Stretch short input pulses so the sampler cannot miss them
    st_next.str = trig_in | (st_reg.str_cnt != 2'h0);
    if (trig_in)
      st_next.str_cnt = trig_io_pkg::STRETCH_LOAD;
    else if (st_reg.str_cnt != 2'h0)
      st_next.str_cnt = st_reg.str_cnt - 2'h1;
    // Two flops before anything looks at the input
    st_next.sync1 = st_reg.str;
    st_next.sync2 = st_reg.sync1;
    st_next.sync_prev = st_reg.sync2;
    // Microsecond timebase
    st_next.us_div = tick ? 6'h00 : st_reg.us_div + 6'h01;
    if (st_reg.pulse_cnt != 5'h00)
      st_next.pulse_cnt = st_reg.pulse_cnt - 5'h01;
    // Run the queued command
    if (exec)
    begin
      st_next.pend = 1'b0;
      case (st_reg.pend_cmd)
        trig_io_pkg::CMD_OUT_ON: st_next.out_en = 1'b1;
        trig_io_pkg::CMD_OUT_OFF: st_next.out_en = 1'b0;
        trig_io_pkg::CMD_START:
        begin
          st_next.armed = 1'b1;
          st_next.frames = 16'h0;
          // Capture starts at once except in hardware start and single shot, which wait
          st_next.acquiring = (st_reg.mode != trig_io_pkg::MODE_HW_START)
            & (st_reg.mode != trig_io_pkg::MODE_SINGLE);
        end
        trig_io_pkg::CMD_STOP:
        begin
          st_next.armed = 1'b0;
          st_next.acquiring = 1'b0;
        end
        default: ;
      endcase
    end
    // A new command after the run one is kept, not lost
    if (cmd_wr)
    begin
      st_next.pend = 1'b1;
      st_next.pend_cmd = trig_io_pkg::cmd_type'(apb_in.pwdata[2:0]);
    end
    // Frame sequencer
    case (st_reg.state)
      // Work out the shutter frame length by adding repetitions
      trig_io_pkg::ST_CALC:
      begin
        if (st_reg.int_us >= trig_io_pkg::READOUT_US)
          st_next.frame_len = st_reg.int_us;
        else if (st_reg.frame_len < trig_io_pkg::READOUT_US)
          st_next.frame_len = st_reg.frame_len + st_reg.int_us;
        if (st_next.frame_len >= trig_io_pkg::READOUT_US)
        begin
          st_next.frame_us = 21'h0;
          st_next.us_div = 6'h00;
          if (st_reg.mode == trig_io_pkg::MODE_SINGLE)
            st_next.state = trig_io_pkg::ST_READY;
          else
          begin
            st_next.state = trig_io_pkg::ST_RUN;
            fire = (st_reg.mode != trig_io_pkg::MODE_EXT_SYNC)
              & (trig_at(st_reg.int_us, st_next.frame_len,
              st_reg.offset_us) == 21'h0);
          end
        end
      end
      // Free-running or externally synchronised frames, also while data waits for the host except in single shot
      trig_io_pkg::ST_RUN, trig_io_pkg::ST_XFER:
      begin
        if (st_reg.mode == trig_io_pkg::MODE_EXT_SYNC)
        begin
          if (tick & ~&st_reg.frame_us)
            st_next.frame_us = st_reg.frame_us + 21'h1;
          // Edge after a full readout time closes the frame
          if (edge_seen & (st_reg.frame_us >= trig_io_pkg::READOUT_US))
          begin
            frame_end = 1'b1;
            fire = 1'b1;
            st_next.frame_us = 21'h0;
          end
        end
        else if (st_reg.mode != trig_io_pkg::MODE_SINGLE & tick)
        begin
          if (st_reg.frame_us == st_reg.frame_len - 21'h1)
          begin
            frame_end = 1'b1;
            st_next.frame_us = 21'h0;
          end
          else
            st_next.frame_us = st_reg.frame_us + 21'h1;
          fire = st_next.frame_us == tpos;
        end
        // Hardware start turns an armed run into a capture
        if (st_reg.mode == trig_io_pkg::MODE_HW_START & st_reg.armed
          & edge_seen)
          st_next.acquiring = 1'b1;
        // Enable mode counts only frames ending with input high
        if (frame_end & st_reg.acquiring
          & (st_reg.state == trig_io_pkg::ST_RUN)
          & ((st_reg.mode != trig_io_pkg::MODE_HW_ENABLE)
          | st_reg.sync2))
        begin
          st_next.frames = st_reg.frames + 16'h1;
          if (st_next.frames == st_reg.scans)
          begin
            st_next.state = trig_io_pkg::ST_XFER;
            st_next.xfer_req = 1'b1;
            st_next.acquiring = 1'b0;
            st_next.armed = 1'b0;
          end
        end
        if ((st_reg.state == trig_io_pkg::ST_XFER) & data_fetched)
        begin
          st_next.xfer_req = 1'b0;
          st_next.state = (st_reg.mode == trig_io_pkg::MODE_SINGLE) ?
            trig_io_pkg::ST_READY : trig_io_pkg::ST_RUN;
        end
      end
      // Clean and ready: in single shot, only here does an edge start a frame
      trig_io_pkg::ST_READY:
      begin
        if (st_reg.armed & edge_seen)
        begin
          st_next.state = trig_io_pkg::ST_INTEG;
          st_next.frame_us = 21'h0;
          st_next.us_div = 6'h00;
          fire = tpos == 21'h0;
        end
      end
      // Single-shot integration
      trig_io_pkg::ST_INTEG:
      begin
        if (tick)
        begin
          if (st_reg.frame_us == st_reg.frame_len - 21'h1)
          begin
            st_next.state = trig_io_pkg::ST_READOUT;
            st_next.frame_us = 21'h0;
            st_next.frames = st_reg.frames + 16'h1;
          end
          else
          begin
            st_next.frame_us = st_reg.frame_us + 21'h1;
            fire = st_next.frame_us == tpos;
          end
        end
      end
      // Readout dead time, edges ignored
      trig_io_pkg::ST_READOUT:
      begin
        if (tick)
        begin
          st_next.frame_us = st_reg.frame_us + 21'h1;
          if (st_reg.frame_us == trig_io_pkg::READOUT_US - 21'h1)
          begin
            st_next.frame_us = 21'h0;
            st_next.state = trig_io_pkg::ST_READY;
            if (st_reg.frames == st_reg.scans)
            begin
              st_next.state = trig_io_pkg::ST_XFER;
              st_next.xfer_req = 1'b1;
              st_next.armed = 1'b0;
            end
          end
        end
      end
      default: st_next.state = trig_io_pkg::ST_CALC;
    endcase
    // Parameter write: store and restart the frame timing
    if (cfg_wr)
    begin
      case (apb_in.paddr)
        trig_io_pkg::ADDR_CTRL:
          st_next.mode = (apb_in.pwdata[2:0] > 3'h4) ?
            trig_io_pkg::MODE_SW_START :
            trig_io_pkg::mode_type'(apb_in.pwdata[2:0]);
        trig_io_pkg::ADDR_INT:
          st_next.int_us = (apb_in.pwdata[20:0] == 21'h0) ? 21'h1 :
            apb_in.pwdata[20:0];
        trig_io_pkg::ADDR_SCANS:
          st_next.scans = (apb_in.pwdata[15:0] == 16'h0) ? 16'h1 :
            apb_in.pwdata[15:0];
        default:
          st_next.offset_us =
            (apb_in.pwdata[10:0] > trig_io_pkg::OFFSET_MAX_US) ?
            trig_io_pkg::OFFSET_MAX_US : apb_in.pwdata[10:0];
      endcase
      st_next.state = trig_io_pkg::ST_CALC;
      st_next.frame_us = 21'h0;
      st_next.frame_len = 21'h0;
      st_next.us_div = 6'h00;
      st_next.armed = 1'b0;
      st_next.acquiring = 1'b0;
      st_next.frames = 16'h0;
      // A restart drops a run whose count closes in the same cycle
      st_next.xfer_req = 1'b0;
      fire = 1'b0;
    end
    // Output pulse; a disable cuts it so nothing leaks out
    if (!st_next.out_en)
      st_next.pulse_cnt = 5'h00;
    else if (fire)
      st_next.pulse_cnt = trig_io_pkg::PULSE_LOAD;
    st_next.trig_out = st_next.pulse_cnt != 5'h00;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= trig_io_pkg::CTL_RESET;
    else
      st_reg <= st_next;
  end

  // Length of the current output high time, for checking
  logic [5:0] hi_cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hi_cnt <= 6'h00;
    else
      hi_cnt <= st_reg.trig_out ? hi_cnt + 6'h01 : 6'h00;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pulse_width:
    assert property ($fell(trig_out) && st_reg.out_en
      |-> hi_cnt == 6'(trig_io_pkg::PULSE_CYC))
    else $error("trigger pulse width wrong");
  a_out_gated:
    assert property (!st_reg.out_en |-> !trig_out)
    else $error("pulse while output disabled");
  a_enable_cmd:
    assert property ($rose(st_reg.out_en) |-> $past(exec)
      && $past(st_reg.pend_cmd) == trig_io_pkg::CMD_OUT_ON)
    else $error("output enabled without command");
  a_cmd_held:
    assert property (st_reg.state == trig_io_pkg::ST_XFER
      && st_reg.pend |=> st_reg.pend)
    else $error("command ran during transfer");
  a_reconf_reset:
    assert property (cfg_wr |=> st_reg.state == trig_io_pkg::ST_CALC
      && st_reg.frame_us == 21'h0 && !st_reg.acquiring)
    else $error("timing not restarted on reconfiguration");
  a_xfer_count:
    assert property ($rose(st_reg.xfer_req) |->
      st_reg.frames == st_reg.scans
      && st_reg.state == trig_io_pkg::ST_XFER)
    else $error("transfer before frame count reached");
  a_ss_ignore:
    assert property (st_reg.state == trig_io_pkg::ST_READOUT
      && edge_seen && !cfg_wr |=> st_reg.state != trig_io_pkg::ST_INTEG)
    else $error("edge accepted during readout");
  a_sync_chain:
    assert property (edge_seen |-> $past(trig_in, 3))
    else $error("edge not from synchronised input");
  a_stretch_len:
    assert property ($rose(st_reg.str) |-> st_reg.str[*3])
    else $error("input stretch too short");
  a_ext_fire:
    assert property (st_reg.state == trig_io_pkg::ST_RUN && !cfg_wr
      && st_reg.mode == trig_io_pkg::MODE_EXT_SYNC && edge_seen
      && st_reg.frame_us >= trig_io_pkg::READOUT_US && st_reg.out_en
      && !exec |=> trig_out && st_reg.frame_us == 21'h0)
    else $error("no pulse at external frame end");

  c_pulse: cover property ($rose(trig_out));
  c_xfer: cover property ($rose(st_reg.xfer_req));
  c_single: cover property (st_reg.state == trig_io_pkg::ST_INTEG);
  c_fetched: cover property ($fell(st_reg.xfer_req));
endmodule

// ==== trig_partner.sv ====
// Partner model: external trigger source and the equipment on trig_out.
// Assumes the pclk domain; fire is a one-cycle request from the bench.
`timescale 1ns/1ps
module trig_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  input wire logic trig_out,
  output logic trig_in,
  output int rises
);
  logic out_prev; // Last sampled trigger output
  // Source sends the shortest pulse a sampled input can carry; between
  // pulses the line rests low, as a pulled-down cable would
  // Equipment counts rising edges and ignores the power-up phase
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      trig_in <= 1'b0;
      out_prev <= 1'b0;
      rises <= 0;
    end
    else
    begin
      trig_in <= fire;
      out_prev <= trig_out;
      rises <= rises + int'(trig_out && !out_prev);
    end
endmodule

// ==== camera_trigger_io_control_bench.sv ====
// Self-checking bench for the trigger I/O controller.
// Assumes a 50 MHz pclk, an APB master and the partner model.
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module camera_trigger_io_control_bench;
  logic pclk = 1'b0; // Bench clock
  logic presetn = 1'b0; // Active-low reset
  trig_io_pkg::apb_in_type apb_in = '0; // Bus request
  trig_io_pkg::apb_out_type apb_out; // Bus answer
  logic trig_in; // From the trigger source
  logic trig_out; // To the equipment
  logic fire = 1'b0; // Source request
  logic data_fetched = 1'b0; // Host side idle here
  logic xfer_req; // Transfer request, too far off to reach here
  int rises; // Edges seen by the equipment
  int bad_count = 0;
  int compares = 0;
  int cycles = 0; // Timeout counter
  int exp_rises = 0; // Model count of output pulses
  int dly; // Cycles until a rise, -1 if none
  int w; // Measured pulse width
  int tint; // Integration time in us
  logic [31:0] rd; // Last read data
  logic err; // Last error answer
  trig_io_ctrl i_trig_io_ctrl (.pclk(pclk), .presetn(presetn),
    .apb_in(apb_in), .apb_out(apb_out), .trig_in(trig_in),
    .data_fetched(data_fetched), .trig_out(trig_out),
    .xfer_req(xfer_req));
  trig_partner i_trig_partner (.pclk(pclk), .presetn(presetn),
    .fire(fire), .trig_out(trig_out), .trig_in(trig_in), .rises(rises));
  always #10 pclk = ~pclk;
  // Cut a hang short; the ceiling covers all scenarios with margin
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      end_sim();
    end
  end
  task automatic end_sim;
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    apb_in.psel <= 1'b1;
    apb_in.penable <= 1'b0;
    apb_in.pwrite <= wr;
    apb_in.paddr <= a;
    apb_in.pwdata <= d;
    @(posedge pclk);
    apb_in.penable <= 1'b1;
    // Wait for the answer; only the bench timeout ends a hang
    do
    begin
      @(posedge pclk);
    end while (apb_out.pready !== 1'b1);
    rd = apb_out.prdata;
    err = apb_out.pslverr;
    apb_in.psel <= 1'b0;
    apb_in.penable <= 1'b0;
    @(posedge pclk);
  endtask
  // One-cycle request to the source, which sends a one-cycle pulse
  task automatic pulse_in;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
  endtask
  // Wait a bounded time for the output to rise
  task automatic wait_rise(input int lim);
    dly = -1;
    for (int i = 0; i < lim; i++)
    begin
      @(posedge pclk);
      if (trig_out === 1'b1)
      begin
        dly = i;
        break;
      end
    end
  endtask
  // Width of a pulse that has just been seen high
  task automatic measure_width;
    w = 0;
    while (trig_out === 1'b1 && w < 100)
    begin
      w++;
      @(posedge pclk);
    end
  endtask
  // Model: cycles from restart to the output event; shutter frames are
  // whole repetitions, the offset only counts in shutter operation
  function automatic int fire_cyc(input int ti, input int off);
    int fl;
    fl = ti;
    while (fl < int'(trig_io_pkg::READOUT_US))
      fl += ti;
    if (ti >= int'(trig_io_pkg::READOUT_US))
      return 0;
    return (fl - ti - off) * trig_io_pkg::US_CYC;
  endfunction
  initial
  begin
    void'($urandom(32'h62B3));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Output disabled after power-up, no pulses
    apb(1'b0, trig_io_pkg::ADDR_STATUS, 32'h0);
    `CHK("status out_en", 1'b0, rd[trig_io_pkg::STAT_OUT_EN])
    // Unmapped place is refused
    apb(1'b0, 8'h20 + 8'(4 * ($urandom % 8)), 32'h0);
    `CHK("unmapped error", 1'b1, err)
    // Configure while disabled: restart must stay silent
    tint = 3710 + $urandom % 100000;
    apb(1'b1, trig_io_pkg::ADDR_CTRL, 32'(trig_io_pkg::MODE_SW_START));
    apb(1'b1, trig_io_pkg::ADDR_OFFSET, 32'($urandom % 1850));
    apb(1'b1, trig_io_pkg::ADDR_INT, 32'(tint));
    wait_rise(100);
    `CHK("no pulse while off", -1, dly)
    apb(1'b0, trig_io_pkg::ADDR_INT, 32'h0);
    `CHK("int readback", 21'(tint), rd[20:0])
    // Enable, then a parameter write restarts the frame at once
    apb(1'b1, trig_io_pkg::ADDR_CMD, 32'(trig_io_pkg::CMD_OUT_ON));
    apb(1'b0, trig_io_pkg::ADDR_STATUS, 32'h0);
    `CHK("status on", 1'b1, rd[trig_io_pkg::STAT_OUT_EN])
    tint = 3710 + $urandom % 100000;
    apb(1'b1, trig_io_pkg::ADDR_INT, 32'(tint));
    wait_rise(20);
    `CHK("frame start pulse", 1'b1, dly >= 0)
    measure_width();
    `CHK("pulse width", trig_io_pkg::PULSE_CYC, w)
    exp_rises++;
    // Shutter frame: off, configure, on; event from the model
    apb(1'b1, trig_io_pkg::ADDR_CMD, 32'(trig_io_pkg::CMD_OUT_OFF));
    apb(1'b1, trig_io_pkg::ADDR_OFFSET, 32'd1849);
    apb(1'b1, trig_io_pkg::ADDR_INT, 32'd1855);
    apb(1'b1, trig_io_pkg::ADDR_CMD, 32'(trig_io_pkg::CMD_OUT_ON));
    wait_rise(fire_cyc(1855, 1849) + 20);
    `CHK("shutter delay", 1'b1, dly >= fire_cyc(1855, 1849) - 15)
    measure_width();
    `CHK("shutter width", trig_io_pkg::PULSE_CYC, w)
    exp_rises++;
    // Hardware start: an input edge turns the armed run into a capture
    apb(1'b1, trig_io_pkg::ADDR_CMD, 32'(trig_io_pkg::CMD_OUT_OFF));
    apb(1'b1, trig_io_pkg::ADDR_CTRL, 32'(trig_io_pkg::MODE_HW_START));
    apb(1'b1, trig_io_pkg::ADDR_CMD, 32'(trig_io_pkg::CMD_START));
    apb(1'b0, trig_io_pkg::ADDR_STATUS, 32'h0);
    `CHK("hw start waits", 1'b0, rd[trig_io_pkg::STAT_ACQ])
    pulse_in();
    repeat (8) @(posedge pclk);
    apb(1'b0, trig_io_pkg::ADDR_STATUS, 32'h0);
    `CHK("hw start edge", 1'b1, rd[trig_io_pkg::STAT_ACQ])
    // Enable mode captures at once; the input only qualifies frames
    apb(1'b1, trig_io_pkg::ADDR_CTRL, 32'(trig_io_pkg::MODE_HW_ENABLE));
    apb(1'b1, trig_io_pkg::ADDR_CMD, 32'(trig_io_pkg::CMD_START));
    apb(1'b0, trig_io_pkg::ADDR_STATUS, 32'h0);
    `CHK("hw enable capture", 1'b1, rd[trig_io_pkg::STAT_ACQ])
    // Single shot: short input pulse starts a frame, later edge ignored
    apb(1'b1, trig_io_pkg::ADDR_CMD, 32'(trig_io_pkg::CMD_OUT_OFF));
    apb(1'b1, trig_io_pkg::ADDR_CTRL, 32'(trig_io_pkg::MODE_SINGLE));
    apb(1'b1, trig_io_pkg::ADDR_OFFSET, 32'h0);
    apb(1'b1, trig_io_pkg::ADDR_INT, 32'd3710);
    apb(1'b1, trig_io_pkg::ADDR_CMD, 32'(trig_io_pkg::CMD_OUT_ON));
    apb(1'b1, trig_io_pkg::ADDR_CMD, 32'(trig_io_pkg::CMD_START));
    wait_rise(20);
    `CHK("no pulse before edge", -1, dly)
    pulse_in();
    wait_rise(20);
    `CHK("single shot pulse", 1'b1, dly >= 0)
    measure_width();
    exp_rises++;
    pulse_in();
    wait_rise(200);
    `CHK("edge while busy", -1, dly)
    `CHK("equipment rises", exp_rises, rises)
    `CHK("no transfer yet", 1'b0, xfer_req)
    end_sim();
  end
endmodule
